// ### rtl/scc_consts.svh
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

`define SCC_ADDR_DATA    3'h0
`define SCC_ADDR_IER     3'h1
`define SCC_ADDR_FCR     3'h2
`define SCC_ADDR_LCR     3'h3
`define SCC_ADDR_MCR     3'h4
`define SCC_ADDR_LSR     3'h5
`define SCC_ADDR_MSR     3'h6
`define SCC_ADDR_SCR     3'h7

`define SCC_FCR_EN       0
`define SCC_FCR_RXCLR    1
`define SCC_FCR_TXCLR    2
`define SCC_FCR_TRIG_LO  6
`define SCC_FCR_TRIG_HI  7

`define SCC_LCR_DIVISOR_ACCESS_BIT     7
`define SCC_LCR_BRK      6
`define SCC_LCR_STICK    5
`define SCC_LCR_EVEN     4
`define SCC_LCR_PEN      3
`define SCC_LCR_STOP     2

`define SCC_MCR_LOOP     4
`define SCC_MCR_IRQ_GATE_OUTPUT     3
`define SCC_MCR_USER_OUTPUT_ONE     2
`define SCC_MCR_RTS      1
`define SCC_MCR_DTR      0

`define SCC_IER_RDA      0
`define SCC_IER_HOLDING_EMPTY_FLAG     1
`define SCC_IER_LS       2

`define SCC_TRIG_1       5'h01
`define SCC_TRIG_4       5'h04
`define SCC_TRIG_8       5'h08
`define SCC_TRIG_14      5'h0e

`define SCC_ID_LS        3'h3
`define SCC_ID_RDA       3'h2
`define SCC_ID_HOLDING_EMPTY_FLAG      3'h1
`define SCC_ID_NONE      3'h0

`define SCC_BIT_TICKS    6'h10
`define SCC_STOP15_TICKS 6'h18
`define SCC_STOP2_TICKS  6'h20
`define SCC_MID_TICK     4'h7
`define SCC_RESET_BYTE   8'h00

`endif

// ### rtl/scc_core.sv
// The register addresses and strobed register access are this design's own decisions.
`include "scc_consts.svh"

module scc_core
  import scc_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin,
  input  wire logic       cts_in_n,
  input  wire logic       dsr_in_n,
  input  wire logic       ring_in_n,
  input  wire logic       carrier_detect_in_n,
  output logic            rts_out_n,
  output logic            dtr_out_n,
  output logic            irq_out,
  output logic            irq_oe_n
);

  function automatic logic [4:0] trig_level(input logic [1:0] code);
    unique case (code)
      2'h0: trig_level = `SCC_TRIG_1;
      2'h1: trig_level = `SCC_TRIG_4;
      2'h2: trig_level = `SCC_TRIG_8;
      2'h3: trig_level = `SCC_TRIG_14;
    endcase
  endfunction

  // Parity over the active data bits only
  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lc);
    logic [7:0] m;
    m = 8'hff >> (2'h3 - lc[1:0]);
    if (lc[`SCC_LCR_STICK]) par_bit = ~lc[`SCC_LCR_EVEN];
    else par_bit = (^(d & m)) ^ ~lc[`SCC_LCR_EVEN];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]      lcr_reg, scr_reg, dll_reg, dlm_reg;
  logic [4:0]      mcr_reg;
  logic [3:0]      ier_reg;
  logic            fifo_en_reg;
  logic [1:0]      trig_reg;
  logic [15:0]     baud_cnt_reg;
  logic [7:0]      tx_mem [DEPTH];
  logic [10:0]     rx_mem [DEPTH];
  logic [AW-1:0]   tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic [AW:0]     tx_cnt_reg, rx_cnt_reg, err_cnt_reg;
  scc_state_type   tx_st_reg, rx_st_reg;
  logic [5:0]      tx_tk_reg;
  logic [3:0]      rx_tk_reg;
  logic [2:0]      tx_idx_reg, rx_idx_reg;
  logic [7:0]      tx_sh_reg, rx_sh_reg;
  logic            tx_line_reg, tx_par_reg, rx_par_reg, rx_zero_reg;
  logic            rx_s1_reg, rx_s2_reg, rx_prev_reg;
  logic [3:0]      mdm_s1_reg, mdm_s2_reg;
  logic            oe_reg, pe_reg, fe_reg, bi_reg, holding_empty_flag_int_reg, holding_empty_flag_prev_reg;
  logic [2:0]      iir_id;

  wire divisor_access_bit      = lcr_reg[`SCC_LCR_DIVISOR_ACCESS_BIT];
  wire loop      = mcr_reg[`SCC_MCR_LOOP];
  wire [1:0] wls = lcr_reg[1:0];
  wire hit_data  = addr == `SCC_ADDR_DATA;
  wire hit_ier   = addr == `SCC_ADDR_IER;
  wire wr_thr    = wr_stb && hit_data && !divisor_access_bit;
  wire wr_dll    = wr_stb && hit_data && divisor_access_bit;
  wire wr_ier    = wr_stb && hit_ier && !divisor_access_bit;
  wire wr_dlm    = wr_stb && hit_ier && divisor_access_bit;
  wire wr_fcr    = wr_stb && addr == `SCC_ADDR_FCR;
  wire wr_lcr    = wr_stb && addr == `SCC_ADDR_LCR;
  wire wr_mcr    = wr_stb && addr == `SCC_ADDR_MCR;
  wire wr_scr    = wr_stb && addr == `SCC_ADDR_SCR;
  wire rd_rbr    = rd_stb && hit_data && !divisor_access_bit;
  wire rd_iir    = rd_stb && addr == `SCC_ADDR_FCR;
  wire rd_lsr    = rd_stb && addr == `SCC_ADDR_LSR;
  wire fcr_on    = wdata[`SCC_FCR_EN];
  // Any write with enable low, or entering FIFO mode, flushes both queues
  wire mode_chg  = wr_fcr && (!fcr_on || !fifo_en_reg);
  wire fcr_apply = wr_fcr && fcr_on;
  wire tx_clear  = mode_chg || (fcr_apply && wdata[`SCC_FCR_TXCLR]);
  wire rx_clear  = mode_chg || (fcr_apply && wdata[`SCC_FCR_RXCLR]);
  wire [AW:0] depth_w = (AW+1)'(DEPTH);
  wire [AW:0] cap     = fifo_en_reg ? depth_w : (AW+1)'(1);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lcr_reg     <= `SCC_RESET_BYTE;
      scr_reg     <= `SCC_RESET_BYTE;
      dll_reg     <= `SCC_RESET_BYTE;
      dlm_reg     <= `SCC_RESET_BYTE;
      mcr_reg     <= '0;
      ier_reg     <= '0;
      fifo_en_reg <= 1'b0;
      trig_reg    <= 2'h0;
    end else begin
      if (wr_lcr) lcr_reg <= wdata;
      if (wr_scr) scr_reg <= wdata;
      if (wr_dll) dll_reg <= wdata;
      if (wr_dlm) dlm_reg <= wdata;
      if (wr_mcr) mcr_reg <= wdata[4:0];
      if (wr_ier) ier_reg <= wdata[3:0];
      if (wr_fcr) fifo_en_reg <= fcr_on;
      if (fcr_apply) trig_reg <= wdata[`SCC_FCR_TRIG_HI:`SCC_FCR_TRIG_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divisor zero wraps to 65536, the top of the range
  wire [15:0] divisor = {dlm_reg, dll_reg};
  wire        tick    = baud_cnt_reg == 16'h0000;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) baud_cnt_reg <= 16'h0000;
    // Restart on a divisor write, else a reset-time 65536 count stalls the new rate
    else if (tick || wr_dll || wr_dlm) baud_cnt_reg <= divisor - 16'h0001;
    else baud_cnt_reg <= baud_cnt_reg - 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  wire       tx_push  = wr_thr && tx_cnt_reg < cap;
  wire       tx_load  = tick && tx_st_reg == st_idle && tx_cnt_reg != '0;
  wire [2:0] last_idx = {1'b0, wls} + 3'h4;
  wire [5:0] stop_len = !lcr_reg[`SCC_LCR_STOP] ? `SCC_BIT_TICKS :
                        (wls == 2'h0) ? `SCC_STOP15_TICKS : `SCC_STOP2_TICKS;
  wire [5:0] bit_len  = (tx_st_reg == st_stop) ? stop_len : `SCC_BIT_TICKS;
  wire       tx_end   = tick && tx_tk_reg == bit_len - 6'h01;
  wire       holding_empty_flag     = tx_cnt_reg == '0;
  wire       transmitter_idle_flag     = holding_empty_flag && tx_st_reg == st_idle;

  always_ff @(posedge clk_sys) begin
    if (tx_push) tx_mem[tx_wp_reg] <= wdata;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_wp_reg  <= '0;
      tx_rp_reg  <= '0;
      tx_cnt_reg <= '0;
    end else if (tx_clear) begin
      tx_wp_reg  <= '0;
      tx_rp_reg  <= '0;
      tx_cnt_reg <= '0;
    end else begin
      if (tx_push) tx_wp_reg <= tx_wp_reg + 1'b1;
      if (tx_load) tx_rp_reg <= tx_rp_reg + 1'b1;
      tx_cnt_reg <= tx_cnt_reg + (AW+1)'(tx_push) - (AW+1)'(tx_load);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_st_reg   <= st_idle;
      tx_tk_reg   <= '0;
      tx_idx_reg  <= '0;
      tx_sh_reg   <= '0;
      tx_par_reg  <= 1'b0;
      tx_line_reg <= 1'b1;
    end else if (tx_load) begin
      tx_sh_reg   <= tx_mem[tx_rp_reg];
      tx_par_reg  <= par_bit(tx_mem[tx_rp_reg], lcr_reg);
      tx_st_reg   <= st_start;
      tx_tk_reg   <= '0;
      tx_line_reg <= 1'b0;
    end else if (tx_st_reg != st_idle && tick) begin
      tx_tk_reg <= tx_end ? 6'h00 : tx_tk_reg + 6'h01;
      if (tx_end) begin
        unique case (tx_st_reg)
          st_start: begin
            tx_st_reg   <= st_data;
            tx_idx_reg  <= 3'h0;
            tx_line_reg <= tx_sh_reg[0];
          end
          st_data: begin
            tx_sh_reg  <= tx_sh_reg >> 1;
            tx_idx_reg <= tx_idx_reg + 3'h1;
            if (tx_idx_reg != last_idx) tx_line_reg <= tx_sh_reg[1];
            else if (lcr_reg[`SCC_LCR_PEN]) begin
              tx_st_reg   <= st_parity;
              tx_line_reg <= tx_par_reg;
            end else begin
              tx_st_reg   <= st_stop;
              tx_line_reg <= 1'b1;
            end
          end
          st_parity: begin
            tx_st_reg   <= st_stop;
            tx_line_reg <= 1'b1;
          end
          st_stop: tx_st_reg <= st_idle;
          st_idle: tx_st_reg <= st_idle;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loopback taps the shifter ahead of the break and marking overrides
  wire       rx_bit   = loop ? tx_line_reg : rx_s2_reg;
  wire       rx_samp  = tick && rx_tk_reg == `SCC_MID_TICK;
  wire       rx_done  = rx_samp && rx_st_reg == st_stop;
  wire [7:0] rx_data  = rx_sh_reg >> (2'h3 - wls);
  wire       rx_fe    = !rx_bit;
  wire       rx_pe    = lcr_reg[`SCC_LCR_PEN] && (rx_par_reg != par_bit(rx_data, lcr_reg));
  wire       rx_bi    = rx_zero_reg && !rx_bit;
  wire       rx_full  = rx_cnt_reg == cap;
  wire       rx_adv   = rx_done && !rx_full;
  wire       rx_write = rx_done && (!rx_full || !fifo_en_reg);
  wire       rx_pop   = rd_rbr && rx_cnt_reg != '0;
  wire       rx_err   = rx_fe || rx_pe || rx_bi;
  wire       head_err = |rx_mem[rx_rp_reg][10:8];

  always_ff @(posedge clk_sys) begin
    if (rx_write) rx_mem[rx_full ? rx_rp_reg : rx_wp_reg] <= {rx_bi, rx_fe, rx_pe, rx_data};
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_wp_reg   <= '0;
      rx_rp_reg   <= '0;
      rx_cnt_reg  <= '0;
      err_cnt_reg <= '0;
    end else if (rx_clear) begin
      rx_wp_reg   <= '0;
      rx_rp_reg   <= '0;
      rx_cnt_reg  <= '0;
      err_cnt_reg <= '0;
    end else begin
      if (rx_adv) rx_wp_reg <= rx_wp_reg + 1'b1;
      if (rx_pop) rx_rp_reg <= rx_rp_reg + 1'b1;
      rx_cnt_reg  <= rx_cnt_reg + (AW+1)'(rx_adv) - (AW+1)'(rx_pop);
      err_cnt_reg <= err_cnt_reg + (AW+1)'(rx_adv && rx_err)
                     - (AW+1)'(rx_pop && head_err);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_s1_reg   <= 1'b1;
      rx_s2_reg   <= 1'b1;
      rx_prev_reg <= 1'b1;
      mdm_s1_reg  <= 4'hf;
      mdm_s2_reg  <= 4'hf;
    end else begin
      rx_s1_reg  <= serial_in_pin;
      rx_s2_reg  <= rx_s1_reg;
      mdm_s1_reg <= {carrier_detect_in_n, ring_in_n, dsr_in_n, cts_in_n};
      mdm_s2_reg <= mdm_s1_reg;
      if (tick) rx_prev_reg <= rx_bit;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_st_reg   <= st_idle;
      rx_tk_reg   <= '0;
      rx_idx_reg  <= '0;
      rx_sh_reg   <= '0;
      rx_par_reg  <= 1'b0;
      rx_zero_reg <= 1'b0;
    end else if (tick) begin
      rx_tk_reg <= rx_tk_reg + 4'h1;
      unique case (rx_st_reg)
        st_idle: begin
          rx_tk_reg <= 4'h0;
          if (!rx_bit && rx_prev_reg) rx_st_reg <= st_start;
        end
        st_start: if (rx_samp) begin
          rx_st_reg   <= rx_bit ? st_idle : st_data;
          rx_idx_reg  <= 3'h0;
          rx_zero_reg <= 1'b1;
        end
        st_data: if (rx_samp) begin
          rx_sh_reg   <= {rx_bit, rx_sh_reg[7:1]};
          rx_zero_reg <= rx_zero_reg && !rx_bit;
          rx_idx_reg  <= rx_idx_reg + 3'h1;
          if (rx_idx_reg == last_idx)
            rx_st_reg <= lcr_reg[`SCC_LCR_PEN] ? st_parity : st_stop;
        end
        st_parity: if (rx_samp) begin
          rx_par_reg  <= rx_bit;
          rx_zero_reg <= rx_zero_reg && !rx_bit;
          rx_st_reg   <= st_stop;
        end
        st_stop: if (rx_samp) rx_st_reg <= st_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set wins over the clearing read in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      oe_reg        <= 1'b0;
      pe_reg        <= 1'b0;
      fe_reg        <= 1'b0;
      bi_reg        <= 1'b0;
      holding_empty_flag_int_reg  <= 1'b0;
      holding_empty_flag_prev_reg <= 1'b1;
    end else begin
      oe_reg        <= (oe_reg && !rd_lsr) || (rx_done && rx_full);
      pe_reg        <= (pe_reg && !rd_lsr) || (rx_done && rx_pe);
      fe_reg        <= (fe_reg && !rd_lsr) || (rx_done && rx_fe);
      bi_reg        <= (bi_reg && !rd_lsr) || (rx_done && rx_bi);
      holding_empty_flag_prev_reg <= holding_empty_flag;
      holding_empty_flag_int_reg  <= (holding_empty_flag_int_reg && !(rd_iir && iir_id == `SCC_ID_HOLDING_EMPTY_FLAG) && !tx_push)
                       || (holding_empty_flag && !holding_empty_flag_prev_reg);
    end
  end

  wire       ls_pend   = ier_reg[`SCC_IER_LS] && (oe_reg || pe_reg || fe_reg || bi_reg);
  wire       rda_pend  = ier_reg[`SCC_IER_RDA] &&
                         (fifo_en_reg ? rx_cnt_reg >= trig_level(trig_reg) : rx_cnt_reg != '0);
  wire       holding_empty_flag_pend = ier_reg[`SCC_IER_HOLDING_EMPTY_FLAG] && holding_empty_flag_int_reg;
  assign iir_id        = ls_pend ? `SCC_ID_LS : rda_pend ? `SCC_ID_RDA :
                         holding_empty_flag_pend ? `SCC_ID_HOLDING_EMPTY_FLAG : `SCC_ID_NONE;
  wire       int_any   = ls_pend || rda_pend || holding_empty_flag_pend;
  wire       lsr7      = fifo_en_reg && err_cnt_reg != '0;
  wire [7:0] lsr_val   = {lsr7, transmitter_idle_flag, holding_empty_flag, bi_reg, fe_reg, pe_reg, oe_reg,
                          rx_cnt_reg != '0};
  wire [3:0] mdm_in    = loop ? {mcr_reg[`SCC_MCR_IRQ_GATE_OUTPUT], mcr_reg[`SCC_MCR_USER_OUTPUT_ONE],
                         mcr_reg[`SCC_MCR_DTR], mcr_reg[`SCC_MCR_RTS]} : ~mdm_s2_reg;
  wire [7:0] iir_val   = {fifo_en_reg, fifo_en_reg, 2'b00, iir_id, !int_any};
  wire [7:0] rd_mux    =
    (hit_data) ? (divisor_access_bit ? dll_reg : rx_mem[rx_rp_reg][7:0]) :
    (hit_ier)  ? (divisor_access_bit ? dlm_reg : {4'h0, ier_reg}) :
    (addr == `SCC_ADDR_FCR) ? iir_val :
    (addr == `SCC_ADDR_LCR) ? lcr_reg :
    (addr == `SCC_ADDR_MCR) ? {3'b000, mcr_reg} :
    (addr == `SCC_ADDR_LSR) ? lsr_val :
    (addr == `SCC_ADDR_MSR) ? {mdm_in, 4'h0} : scr_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata          <= 8'h00;
      serial_out_pin <= 1'b1;
      rts_out_n      <= 1'b1;
      dtr_out_n      <= 1'b1;
      irq_out        <= 1'b0;
      irq_oe_n       <= 1'b1;
    end else begin
      rdata          <= rd_stb ? rd_mux : 8'h00;
      serial_out_pin <= loop ? 1'b1 : lcr_reg[`SCC_LCR_BRK] ? 1'b0 : tx_line_reg;
      rts_out_n      <= loop || !mcr_reg[`SCC_MCR_RTS];
      dtr_out_n      <= loop || !mcr_reg[`SCC_MCR_DTR];
      irq_out        <= mcr_reg[`SCC_MCR_IRQ_GATE_OUTPUT] && int_any;
      irq_oe_n       <= !mcr_reg[`SCC_MCR_IRQ_GATE_OUTPUT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  break_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    lcr_reg[`SCC_LCR_BRK] && !loop |=> !serial_out_pin)
    else $error("break not driving spacing");
  loop_mark_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    loop |=> serial_out_pin && rts_out_n && dtr_out_n)
    else $error("loopback pins not inactive");
  rts_inverse_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !loop && mcr_reg[`SCC_MCR_RTS] |=> !rts_out_n)
    else $error("request pin not inverted");
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !mcr_reg[`SCC_MCR_IRQ_GATE_OUTPUT] |=> !irq_out && irq_oe_n)
    else $error("interrupt not gated off");
  fifo_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_fcr && !fcr_on |=> !fifo_en_reg && tx_cnt_reg == '0 && rx_cnt_reg == '0)
    else $error("fifo disable did not flush");
  transmitter_idle_flag_busy_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_lsr && tx_cnt_reg != '0 |=> !rdata[6] && !rdata[5])
    else $error("transmitter empty while loaded");
  err_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_lsr && !rx_done |=> !pe_reg && !fe_reg && !oe_reg)
    else $error("error flags survive status read");
  dr_empty_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_lsr ##1 $past(rx_cnt_reg) == '0 |-> !rdata[0])
    else $error("data ready with empty buffer");
  mcr_top_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_stb && addr == `SCC_ADDR_MCR |=> rdata[7:5] == 3'b000)
    else $error("control top bits not zero");
  summary_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_lsr && !fifo_en_reg |=> !rdata[7])
    else $error("error summary set outside fifo mode");

endmodule

// ### rtl/scc_pkg.sv
package scc_pkg;
  typedef enum logic [2:0] {st_idle, st_start, st_data, st_parity, st_stop} scc_state_type;
endpackage

// ### testbench/scc_far_end.sv
module scc_far_end (
  input  wire logic clk_sys,
  input  wire logic serial_out_pin,
  output logic      serial_in_pin,
  output logic      cts_in_n,
  output logic      dsr_in_n,
  output logic      ring_in_n,
  output logic      carrier_detect_in_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // Fixed modem levels, so status reads have one answer
  assign cts_in_n            = 1'b0;
  assign dsr_in_n            = 1'b1;
  assign ring_in_n           = 1'b0;
  assign carrier_detect_in_n = 1'b1;

  initial serial_in_pin = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Start bit, then caller's bits (data, parity, stop) at 16 clocks per bit
  task automatic send(input logic [11:0] b, input int n);
    serial_in_pin <= 1'b0;
    repeat (16) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      serial_in_pin <= b[i];
      repeat (16) @(posedge clk_sys);
    end
    // Back to mark; idle time lets the receiver store the character
    serial_in_pin <= 1'b1;
    repeat (24) @(posedge clk_sys);
  endtask

  // Samples mid-bit; only the first stop bit is looked at
  task automatic catch(input int n, output logic [11:0] b);
    b = 12'h000;
    wait (serial_out_pin === 1'b0);
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge clk_sys);
      b[i] = serial_out_pin;
    end
  endtask
endmodule

// ### testbench/test_serial_channel_core.sv
module test_serial_channel_core;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk_sys = 1'b0;
  logic       rstn    = 1'b0;
  logic [2:0] addr    = 3'h0;
  logic [7:0] wdata   = 8'h00;
  logic       wr_stb  = 1'b0;
  logic       rd_stb  = 1'b0;
  logic [7:0] rdata;
  logic       serial_in_pin;
  logic       serial_out_pin;
  logic       cts_in_n;
  logic       dsr_in_n;
  logic       ring_in_n;
  logic       carrier_detect_in_n;
  logic       rts_out_n;
  logic       dtr_out_n;
  logic       irq_out;
  logic       irq_oe_n;
  int         failures    = 0;
  int         comparisons = 0;

`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

  scc_core u_dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .cts_in_n(cts_in_n), .dsr_in_n(dsr_in_n),
    .ring_in_n(ring_in_n), .carrier_detect_in_n(carrier_detect_in_n),
    .rts_out_n(rts_out_n), .dtr_out_n(dtr_out_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n));

  scc_far_end u_far (.clk_sys(clk_sys), .serial_out_pin(serial_out_pin),
    .serial_in_pin(serial_in_pin), .cts_in_n(cts_in_n), .dsr_in_n(dsr_in_n),
    .ring_in_n(ring_in_n), .carrier_detect_in_n(carrier_detect_in_n));

  initial forever #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] ex);
    logic [7:0] d;
    rd(a, d);
    `CHK("register", ex, d)
  endtask

  // Expected frame after the start bit: data, parity, one stop
  function automatic logic [11:0] frm(input logic [7:0] f, input logic [7:0] d);
    int          nb;
    logic [11:0] b;
    nb = 5 + f[1:0];
    b  = {4'h0, d} & ((12'h001 << nb) - 12'h001);
    if (f[3]) b[nb] = f[5] ? ~f[4] : (f[4] ? ^b : ~^b);
    b[nb + f[3]] = 1'b1;
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rchk(3'h5, 8'h60);
    `CHK("rts", 1'b1, rts_out_n)
    wr(3'h7, 8'h5a);
    rchk(3'h7, 8'h5a);
    wr(3'h1, 8'h05);
    wr(3'h3, 8'h80);
    // Divisor 1 keeps each bit at 16 clocks
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    rchk(3'h0, 8'h01);
    rchk(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    rchk(3'h1, 8'h05);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'he7);
    rchk(3'h4, 8'h07);
    `CHK("rts", 1'b0, rts_out_n)
    `CHK("dtr", 1'b0, dtr_out_n)
    `CHK("irq_oe", 1'b1, irq_oe_n)
    wr(3'h4, 8'h08);
    repeat (2) @(posedge clk_sys);
    `CHK("irq_oe", 1'b0, irq_oe_n)
    wr(3'h4, 8'h00);
    rchk(3'h6, 8'h50);
  endtask

  task automatic t_tx();
    logic [7:0]  fmt [6] = '{8'h03, 8'h1a, 8'h0a, 8'h38, 8'h29, 8'h07};
    logic [11:0] got;
    logic [7:0]  st;
    foreach (fmt[i]) begin
      wr(3'h3, fmt[i]);
      wr(3'h0, 8'h35 ^ fmt[i]);
      fork
        u_far.catch(6 + fmt[i][1:0] + fmt[i][3], got);
        begin
          rd(3'h5, st);
          `CHK("busy", 1'b0, st[6])
        end
      join
      `CHK("frame", frm(fmt[i], 8'h35 ^ fmt[i]), got)
      // Middle of a second stop bit, if one is sent
      repeat (14) @(posedge clk_sys);
      rd(3'h5, st);
      `CHK("stop", ~fmt[i][2], st[6])
      repeat (16) @(posedge clk_sys);
    end
    wr(3'h3, 8'h43);
    repeat (20) @(posedge clk_sys);
    `CHK("break_out", 1'b0, serial_out_pin)
    wr(3'h3, 8'h03);
    repeat (3) @(posedge clk_sys);
    `CHK("break_out", 1'b1, serial_out_pin)
  endtask

  task automatic t_rx();
    logic [7:0] st;
    wr(3'h3, 8'h1b);
    wr(3'h1, 8'h04);
    wr(3'h4, 8'h08);
    u_far.send(frm(8'h1b, 8'h3c), 10);
    rchk(3'h5, 8'h61);
    rchk(3'h0, 8'h3c);
    rchk(3'h5, 8'h60);
    u_far.send(frm(8'h1b, 8'h3d) ^ 12'h100, 10);
    `CHK("irq", 1'b1, irq_out)
    rchk(3'h5, 8'h65);
    repeat (2) @(posedge clk_sys);
    `CHK("irq", 1'b0, irq_out)
    rchk(3'h5, 8'h61);
    rchk(3'h0, 8'h3d);
    u_far.send(frm(8'h1b, 8'h3e) ^ 12'h200, 10);
    rchk(3'h5, 8'h69);
    rchk(3'h0, 8'h3e);
    u_far.send(12'h000, 12);
    rd(3'h5, st);
    `CHK("break_in", 1'b1, st[4])
    rd(3'h0, st);
    u_far.send(frm(8'h1b, 8'h01), 10);
    u_far.send(frm(8'h1b, 8'h02), 10);
    rchk(3'h5, 8'h63);
    rchk(3'h0, 8'h02);
    wr(3'h3, 8'h03);
  endtask

  task automatic t_fifo();
    logic [4:0]  lvl [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
    logic [11:0] g1;
    logic [11:0] g2;
    logic [7:0]  st;
    wr(3'h1, 8'h01);
    for (int c = 0; c < 4; c++) begin
      // Reserved and ready-mode bits set on purpose
      wr(3'h2, {2'(c), 6'h3b});
      repeat (2) @(posedge clk_sys);
      for (int i = 0; i < lvl[c]; i++) begin
        `CHK("trigger", 1'b0, irq_out)
        u_far.send(frm(8'h03, 8'h40), 9);
      end
      `CHK("trigger", 1'b1, irq_out)
    end
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h03);
    for (int i = 0; i < 17; i++) u_far.send(frm(8'h03, 8'(i)), 9);
    rchk(3'h5, 8'h63);
    for (int i = 0; i < 16; i++) rchk(3'h0, 8'(i));
    u_far.send(frm(8'h03, 8'h51) ^ 12'h100, 9);
    u_far.send(frm(8'h03, 8'h52), 9);
    rchk(3'h5, 8'he9);
    rchk(3'h5, 8'he1);
    rchk(3'h0, 8'h51);
    rchk(3'h5, 8'h61);
    rchk(3'h0, 8'h52);
    fork
      begin
        u_far.catch(9, g1);
        u_far.catch(9, g2);
      end
      begin
        wr(3'h0, 8'h11);
        wr(3'h0, 8'h22);
        rd(3'h5, st);
        `CHK("hold", 1'b0, st[5])
      end
    join
    `CHK("frame", frm(8'h03, 8'h11), g1)
    `CHK("frame", frm(8'h03, 8'h22), g2)
    repeat (20) @(posedge clk_sys);
    rchk(3'h5, 8'h60);
    u_far.send(frm(8'h03, 8'h53), 9);
    wr(3'h2, 8'h03);
    rchk(3'h5, 8'h60);
    u_far.send(frm(8'h03, 8'h54), 9);
    wr(3'h2, 8'h00);
    rchk(3'h5, 8'h60);
  endtask

  task automatic t_loop();
    int bad = 0;
    wr(3'h4, 8'h1f);
    rchk(3'h6, 8'hf0);
    wr(3'h0, 8'h5e);
    repeat (200) begin
      @(posedge clk_sys);
      if (serial_out_pin !== 1'b1) bad++;
    end
    `CHK("mark", 0, bad)
    rchk(3'h0, 8'h5e);
    `CHK("rts", 1'b1, rts_out_n)
    `CHK("dtr", 1'b1, dtr_out_n)
    wr(3'h4, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_fifo();
    t_loop();
    conclude();
  end

  // About 12000 cycles expected; five times that means a hang
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    $display("MISMATCH watchdog expected done seen hung");
    conclude();
  end
endmodule
